// ### rd_checker_assertions.sv
`timescale 1ns/1ps
`include "rst_dist_regs.vh"

module rd_checker (
    // watched ports
    input wire clock_i,
    input wire nrst_i,
    input wire low_voltage_reset_i,
    input wire ext_reset_pin_n_i,
    input wire watchdog_reset_i,
    input wire clock_loss_reset_i,
    input wire stop_ack_error_reset_i,
    input wire debug_reset_i,
    input wire flash_blank_i,
    input wire [`NUM_MOD-1:0] mod_reset_o,
    input wire [`NUM_MOD-1:0] retained_reset_o,
    input wire boot_source_o,
    input wire [31:0] vector_base_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);
    // a request sampled at one edge shows on the outputs two samples later, a pin request six
    a_watchdog_sys: assert property (watchdog_reset_i |-> ##2
        (mod_reset_o & 10'h27f) == 10'h27f) else $error("watchdog reset");
    a_pin_sys: assert property ($fell(ext_reset_pin_n_i) |-> ##6
        (mod_reset_o & 10'h27f) == 10'h27f) else $error("pin reset");
    a_clk_loss: assert property (clock_loss_reset_i |-> ##2
        (mod_reset_o & 10'h27f) == 10'h27f) else $error("clock loss");
    a_stop_ack: assert property (stop_ack_error_reset_i |-> ##2
        (mod_reset_o & 10'h27f) == 10'h27f) else $error("stop ack");
    a_dbg_sys: assert property (debug_reset_i |-> ##2
        (mod_reset_o & 10'h27f) == 10'h27f) else $error("debug reset");
    a_lowv_mask: assert property (low_voltage_reset_i |-> ##2
        (mod_reset_o & 10'h37f) == 10'h37f) else $error("low voltage reset");
    a_lowv_keep: assert property (low_voltage_reset_i |-> ##2
        retained_reset_o == 10'h37e) else $error("low voltage retained");
    a_rtc_kept: assert property (!$rose(mod_reset_o[`M_RTC]))
        else $error("rtc reset");
    a_lpt_lowv_only: assert property ($rose(mod_reset_o[`M_LPT]) |->
        $past(low_voltage_reset_i, 2)) else $error("lp timer reset");
    a_retain_por: assert property ($rose(|retained_reset_o) |->
        $past(low_voltage_reset_i, 2)) else $error("retained reset");
    a_boot_vec: assert property (vector_base_o ==
        (boot_source_o ? `ROM_BASE : `FLASH_BASE)) else $error("vector");
    a_boot_pick: assert property ($fell(mod_reset_o[`M_OTH]) |->
        boot_source_o == $past(flash_blank_i, 2)) else $error("boot pick");
    a_hold_drop: assert property ($fell(watchdog_reset_i) |->
        mod_reset_o[`M_OTH] [*8] ##1 mod_reset_o[`M_OTH] ##1
        mod_reset_o[`M_OTH] ##1 !mod_reset_o[`M_OTH])
        else $error("early release");
endmodule

bind reset_distribution_and_boot_select rd_checker rd_checker_inst (
    .clock_i, .nrst_i, .low_voltage_reset_i, .ext_reset_pin_n_i,
    .watchdog_reset_i, .clock_loss_reset_i, .stop_ack_error_reset_i,
    .debug_reset_i, .flash_blank_i, .mod_reset_o, .retained_reset_o,
    .boot_source_o, .vector_base_o
);

// ### rd_source_model.sv
`timescale 1ns/1ps

module rd_source_model (
    // clock
    input wire logic clock_i,
    // request command
    input wire logic [3:0] sel_i,
    input wire logic go_i,
    // request levels, one per source index
    output logic [9:0] req_o
);
    initial req_o = 10'h000;
    // one source at a time, changed only just after an edge
    always @(posedge clock_i) begin
        req_o <= go_i ? (10'h001 << sel_i) : 10'h000;
    end
endmodule

// ### reset_distribution_and_boot_select.v
// Function
// - a source marked as affecting a module resets all of it except kept parts.
// - a source marked as not affecting a module leaves it untouched.
// - pin, watchdog, software, lockup reset all but clock and timer; pin negated.
// - clock loss and lock loss act as system resets, sparing clock and timer.
// - stop acknowledge error is a system reset sparing clock and timer.
// - debug port system reset and debug reset spare clock and timer too.
// - boot comes from internal flash or boot rom only.
// - blank device boots from rom and maps vectors to rom base.
// - programmed device maps vectors to flash base.
`timescale 1ns/1ps
`include "rst_dist_regs.vh"

module reset_distribution_and_boot_select (
    // clock and power-on reset
    input wire clock_i,
    input wire nrst_i,
    // reset requests from monitors and pin
    input wire low_voltage_reset_i,
    input wire ext_reset_pin_n_i,
    input wire watchdog_reset_i,
    input wire clock_loss_reset_i,
    input wire lock_loss_reset_i,
    input wire stop_ack_error_reset_i,
    input wire lockup_reset_i,
    input wire debug_sys_reset_i,
    input wire debug_reset_i,
    // boot strap
    input wire flash_blank_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    // module reset lines, active high
    output reg [`NUM_MOD-1:0] mod_reset_o,
    output reg [`NUM_MOD-1:0] retained_reset_o,
    output reg reset_pin_drive_o,
    // boot selection
    output reg boot_source_o,
    output reg [31:0] vector_base_o
);

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    reg [2:0] pin_sync_q;
    reg pin_req_q;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_sync_q <= 3'h7;
            pin_req_q <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], ext_reset_pin_n_i};
            if (pin_sync_q[2] == pin_sync_q[1])
                pin_req_q <= ~pin_sync_q[2];
        end
    end

    // ------------------------------------------------------------
    // software control register
    // ------------------------------------------------------------
    reg [2:0] ctrl_q;
    wire wr_en = psel_i & penable_i & pwrite_i;
    wire ctrl_wr = wr_en & (paddr_i == `RD_CTRL_OFS);

    // ------------------------------------------------------------
    // source collection
    // ------------------------------------------------------------
    wire [`NUM_SRC-1:0] src_req;
    assign src_req[`SRC_LOWV] = low_voltage_reset_i;
    assign src_req[`SRC_PIN] = pin_req_q;
    assign src_req[`SRC_WDT] = watchdog_reset_i;
    assign src_req[`SRC_CLKLOSS] = clock_loss_reset_i;
    assign src_req[`SRC_LOCKLOSS] = lock_loss_reset_i;
    assign src_req[`SRC_SACK] = stop_ack_error_reset_i;
    assign src_req[`SRC_SOFT] = ctrl_q[`CTRL_SWRST_BIT];
    assign src_req[`SRC_LOCKUP] = lockup_reset_i;
    assign src_req[`SRC_DAP] = debug_sys_reset_i |
                               ctrl_q[`CTRL_DAPRST_BIT];
    assign src_req[`SRC_DBG] = debug_reset_i |
                               ctrl_q[`CTRL_DBGRST_BIT];

    wire lowv_req = src_req[`SRC_LOWV];
    // every system source other than low voltage shares one column
    wire sys_req = |src_req[`NUM_SRC-1:1];

    // ------------------------------------------------------------
    // reset stretch counter
    // ------------------------------------------------------------
    reg [3:0] hold_q;
    reg lowv_act_q;
    reg sys_act_q;
    reg [`NUM_SRC-1:0] cause_q;
    reg por_flag_q;
    wire any_req = lowv_req | sys_req;

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hold_q <= `RST_HOLD_CYC;
            lowv_act_q <= 1'b0;
            sys_act_q <= 1'b0;
            cause_q <= {`NUM_SRC{1'b0}};
            por_flag_q <= 1'b1;
            ctrl_q <= 3'h0;
        end else begin
            if (any_req) begin
                hold_q <= `RST_HOLD_CYC;
                lowv_act_q <= lowv_act_q | lowv_req;
                sys_act_q <= sys_act_q | sys_req;
                cause_q <= src_req;
                por_flag_q <= 1'b0;
            end else if (hold_q != 4'h0) begin
                hold_q <= hold_q - 4'h1;
            end else begin
                lowv_act_q <= 1'b0;
                sys_act_q <= 1'b0;
            end
            // self-clearing request bits, dropped once a reset starts
            if (ctrl_wr)
                ctrl_q <= pwdata_i[2:0];
            else if (any_req)
                ctrl_q <= 3'h0;
        end
    end

    // ------------------------------------------------------------
    // reset matrix
    // ------------------------------------------------------------
    reg [`NUM_MOD-1:0] mod_d;
    reg [`NUM_MOD-1:0] ret_d;
    wire por_phase = por_flag_q & (hold_q != 4'h0);
    always @* begin
        mod_d = {`NUM_MOD{1'b0}};
        ret_d = {`NUM_MOD{1'b0}};
        if (por_phase) begin
            mod_d = {`NUM_MOD{1'b1}};
            ret_d = {`NUM_MOD{1'b1}};
        end else begin
            if (lowv_act_q) begin
                mod_d = {`NUM_MOD{1'b1}};
                mod_d[`M_RTC] = 1'b0;
                // only the power unit thresholds and the rtc survive low voltage
                ret_d = {`NUM_MOD{1'b1}};
                ret_d[`M_RTC] = 1'b0;
                ret_d[`M_PMU] = 1'b0;
            end
            if (sys_act_q) begin
                mod_d = mod_d | {`NUM_MOD{1'b1}};
                mod_d[`M_RTC] = 1'b0;
                mod_d[`M_LPT] = lowv_act_q;
            end
            // retained settings stay out of reset unless low voltage is active
        end
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mod_reset_o <= {`NUM_MOD{1'b1}};
            retained_reset_o <= {`NUM_MOD{1'b1}};
            reset_pin_drive_o <= 1'b1;
        end else begin
            mod_reset_o <= mod_d;
            retained_reset_o <= ret_d;
            reset_pin_drive_o <= mod_d[`M_PIN];
        end
    end

    // ------------------------------------------------------------
    // boot selection, sampled at reset release
    // ------------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_source_o <= `BOOT_ROM;
            vector_base_o <= `ROM_BASE;
        end else if (mod_d[`M_OTH]) begin
            if (flash_blank_i) begin
                boot_source_o <= `BOOT_ROM;
                vector_base_o <= `ROM_BASE;
            end else begin
                boot_source_o <= `BOOT_FLASH;
                vector_base_o <= `FLASH_BASE;
            end
        end
    end

    // ------------------------------------------------------------
    // apb read path, zero wait states
    // ------------------------------------------------------------
    reg [31:0] rd_d;
    reg err_d;
    always @* begin
        rd_d = 32'h0;
        err_d = 1'b0;
        case (paddr_i)
            `RD_CTRL_OFS: rd_d = {29'h0, ctrl_q};
            `RD_STAT_OFS: rd_d = {29'h0, por_flag_q, sys_act_q, lowv_act_q};
            `RD_CAUSE_OFS: rd_d = {22'h0, cause_q};
            `RD_BOOT_OFS: rd_d = {31'h0, boot_source_o};
            default: err_d = 1'b1;
        endcase
    end

    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & err_d;
            if (psel_i & ~penable_i & ~pwrite_i)
                prdata_o <= rd_d;
        end
    end

endmodule

// ### reset_distribution_and_boot_select_test.sv
`timescale 1ns/1ps
`include "rst_dist_regs.vh"

module reset_distribution_and_boot_select_test;
    logic clock_i = 0, nrst_i = 0, blank = 1, go = 0;
    logic psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 0;
    logic [31:0] pwdata_i = 0, prdata_o, vec, rd;
    logic pready_o, pslverr_o, boot, pin, err;
    logic [3:0] sel = 0;
    logic [9:0] req, mr, rr;
    int error_cnt = 0, n_checks = 0;
    always #10 clock_i = ~clock_i;
    rd_source_model rd_source_model_inst (.clock_i(clock_i),
        .sel_i(sel), .go_i(go), .req_o(req));
    reset_distribution_and_boot_select
        reset_distribution_and_boot_select_inst (
        .clock_i(clock_i), .nrst_i(nrst_i),
        .low_voltage_reset_i(req[0]), .ext_reset_pin_n_i(~req[1]),
        .watchdog_reset_i(req[2]), .clock_loss_reset_i(req[3]),
        .lock_loss_reset_i(req[4]), .stop_ack_error_reset_i(req[5]),
        .lockup_reset_i(req[7]), .debug_sys_reset_i(req[8]),
        .debug_reset_i(req[9]), .flash_blank_i(blank), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mod_reset_o(mr), .retained_reset_o(rr),
        .reset_pin_drive_o(pin), .boot_source_o(boot),
        .vector_base_o(vec));
    task conclude;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        // start just after an edge so back to back calls never overlap
        @(posedge clock_i);
        psel_i <= 1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1;
        k = 0;
        do begin
            @(posedge clock_i);
            k++;
        end while (pready_o !== 1 && k < 20);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
        if (pready_o !== 1) begin
            error_cnt++;
            conclude();
        end
    endtask
    task wait_mod(input logic [9:0] v);
        int k;
        k = 0;
        while (mr !== v && k < 40) begin
            @(posedge clock_i);
            k++;
        end
        if (k >= 40) begin
            error_cnt++;
            conclude();
        end
    endtask
    initial begin
        repeat (2) @(posedge clock_i);
        nrst_i <= 1;
        wait_mod(10'h000);
        chk("boot", `BOOT_ROM, boot);
        chk("vector", `ROM_BASE, vec);
        chk("pin drive", 0, pin);
        apb(0, `RD_STAT_OFS, 0);
        chk("status", 32'h4, rd);
        blank <= 0;
        for (int s = 0; s < 10; s++) begin
            if (s == `SRC_SOFT) apb(1, `RD_CTRL_OFS, 32'h1);
            else begin
                sel <= s;
                go <= 1;
                repeat (3) @(posedge clock_i);
                go <= 0;
            end
            wait_mod(s == 0 ? 10'h37f : 10'h27f);
            chk("mask", s == 0 ? 10'h37f : 10'h27f, mr);
            chk("retained", s == 0 ? 10'h37e : 10'h000, rr);
            chk("pin drive", 1, pin);
            wait_mod(10'h000);
            @(posedge clock_i);
            apb(0, `RD_CAUSE_OFS, 0);
            chk("cause", 32'h1 << s, rd);
        end
        chk("boot", `BOOT_FLASH, boot);
        chk("vector", `FLASH_BASE, vec);
        // debug port and debug resets requested through the control word
        for (int b = 1; b < 3; b++) begin
            apb(1, `RD_CTRL_OFS, 32'h1 << b);
            wait_mod(10'h27f);
            chk("ctrl mask", 10'h27f, mr);
            wait_mod(10'h000);
            apb(0, `RD_CAUSE_OFS, 0);
            chk("ctrl cause", 32'h1 << (b + 7), rd);
            apb(0, `RD_CTRL_OFS, 0);
            chk("ctrl clear", 0, rd);
        end
        apb(0, `RD_BOOT_OFS, 0);
        chk("boot reg", `BOOT_FLASH, rd);
        apb(0, 12'h010, 0);
        chk("slverr", 1, err);
        conclude();
    end
endmodule

// ### rst_dist_regs.vh
`ifndef RST_DIST_REGS_VH
`define RST_DIST_REGS_VH

// register byte offsets
`define RD_CTRL_OFS 12'h000
`define RD_STAT_OFS 12'h004
`define RD_CAUSE_OFS 12'h008
`define RD_BOOT_OFS 12'h00c

// reset source indices
`define SRC_LOWV 0
`define SRC_PIN 1
`define SRC_WDT 2
`define SRC_CLKLOSS 3
`define SRC_LOCKLOSS 4
`define SRC_SACK 5
`define SRC_SOFT 6
`define SRC_LOCKUP 7
`define SRC_DAP 8
`define SRC_DBG 9
`define NUM_SRC 10

// control register fields
`define CTRL_SWRST_BIT 0
`define CTRL_DAPRST_BIT 1
`define CTRL_DBGRST_BIT 2

// boot selections and vector bases
`define BOOT_FLASH 1'b0
`define BOOT_ROM 1'b1
`define FLASH_BASE 32'h0000_0000
`define ROM_BASE 32'h1c00_0000

// module reset line indices
`define M_PMU 0
`define M_SIU 1
`define M_PMODE 2
`define M_RCU 3
`define M_PIN 4
`define M_WDG 5
`define M_CLKGEN 6
`define M_RTC 7
`define M_LPT 8
`define M_OTH 9
`define NUM_MOD 10

// reset stretch counter reload in cycles; a requested reset pulse lasts one cycle more
`define RST_HOLD_CYC 4'h8

`endif
